// ===== hdl/dcr_pkg.sv
// Purpose: constants for the dialer control register bank
// Assumes: 4-bit memory-mapped access, 25 MHz clock
// Notes:   timing counts derived from printed times
package dcr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [15:0] ADDR_DIAL_MODE   = 16'hFF10;
  localparam logic [15:0] ADDR_PAUSE_TIME  = 16'hFF11;
  localparam logic [15:0] ADDR_FLASH_TIME  = 16'hFF12;
  localparam logic [15:0] ADDR_STAT_SEL    = 16'hFF13;
  localparam logic [15:0] ADDR_LINE_FUNC   = 16'hFF14;
  localparam logic [15:0] ADDR_IDP_TIME    = 16'hFF15;
  localparam logic [15:0] ADDR_TONE_CTRL   = 16'hFF16;
  localparam logic [15:0] ADDR_DIAL_DIGIT  = 16'hFF17;
  localparam logic [15:0] ADDR_HOOK_MUTE   = 16'hFF18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_TONE_PULSE = 3;
  localparam int BIT_MAKE_BREAK = 1;
  localparam int BIT_PULSE_RATE = 0;
  localparam int BIT_HF_SEL     = 3;
  localparam int BIT_HOLD       = 2;
  localparam int BIT_PAUSE_TRIG = 1;
  localparam int BIT_FLASH_TRIG = 0;
  localparam int BIT_CONT_TONE  = 3;
  localparam int BIT_ROW_EN     = 1;
  localparam int BIT_COL_EN     = 0;
  localparam int BIT_HOOK       = 3;
  localparam int BIT_RX_MUTE    = 1;
  localparam int BIT_TX_MUTE    = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_DIAL_MODE  = 4'h0;
  localparam logic [3:0] RST_PAUSE_TIME = 4'h4;
  localparam logic [3:0] RST_FLASH_TIME = 4'h6;
  localparam logic [3:0] RST_STAT_SEL   = 4'h0;
  localparam logic [3:0] RST_LINE_FUNC  = 4'h0;
  localparam logic [3:0] RST_IDP_TIME   = 4'h8;
  localparam logic [3:0] RST_TONE_CTRL  = 4'h3;
  localparam logic [3:0] RST_DIAL_DIGIT = 4'h0;
  localparam logic [3:0] RST_HOOK_MUTE  = 4'h3;
  localparam logic [3:0] RST_PORT_R1    = 4'hF;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int STEP_US        = 93_750;    // 1/10.667 s flash step
  localparam int STEP_CYC       = STEP_US * (CLK_HZ / 1_000_000);
  localparam int PAUSE_SEC_CYC  = CLK_HZ;
  localparam int PULSE10_US     = 100_000;
  localparam int PULSE20_US     = 50_000;
  localparam int PULSE10_CYC    = PULSE10_US * (CLK_HZ / 1_000_000);
  localparam int PULSE20_CYC    = PULSE20_US * (CLK_HZ / 1_000_000);
  localparam int TONE_US        = 100_000;
  localparam int TONE_CYC       = TONE_US * (CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_MAKE  = 3'b001,
    ST_BREAK = 3'b010,
    ST_IDP   = 3'b011,
    ST_PAUSE = 3'b100,
    ST_FLASH = 3'b101,
    ST_TONE  = 3'b110
  } dcr_state_e;

endpackage : dcr_pkg

// ===== hdl/dcr_top.sv
// Purpose: dialer control registers with pulse, pause and flash sequencing
// Assumes: 4-bit cpu bus on mclk_i, one-cycle read and write strobes
// Notes:   long counts are parameters so a simulation can shorten them
// Operation
// - tone_pulse_sel 1 selects pulse dialing, 0 tone; resets to 0
// - make_break_ratio_sel 1 gives 33.3:66.6, 0 gives 40:60
// - dial_pulse_rate_sel 1 gives 20 pps, 0 gives 10 pps
// - pause_time_sel codes 1..15 give that many seconds; resets to 4 s
// - flash_time_sel codes 1..15 give 94 ms steps; resets to 563 ms
// - inter-digit pause uses same step table; resets to 750 ms
// - writing 1 to pause or flash trigger starts it when idle and its time code is nonzero, pause winning if both; reads 0
// - continuous_tone_on keeps tone running without timing
// - row_tone_enable gates row frequency; both enables reset to 1
// - column_tone_enable gates column frequency
// - dial_digit_code holds digit; pulse count or tone pair
// - hook_switch_ctrl 1 means hook switch off, 0 on
// - receive and transmit mute follow their bits; both reset muted
// - output selects route status signals onto shared port pins
// - unused bits and trigger bits read as 0
`timescale 1ns/1ns
module dcr_top #(
  parameter int PAUSE_SEC_CYC = dcr_pkg::PAUSE_SEC_CYC,
  parameter int STEP_CYC      = dcr_pkg::STEP_CYC,
  parameter int PULSE10_CYC   = dcr_pkg::PULSE10_CYC,
  parameter int PULSE20_CYC   = dcr_pkg::PULSE20_CYC,
  parameter int TONE_CYC      = dcr_pkg::TONE_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [3:0]  wdata_i,
  input  wire logic        dial_start_i,
  input  wire logic [3:0]  port_r1_data_i,
  output logic      [3:0]  rdata_o,
  output logic             dial_pulse_o,
  output logic             tone_on_o,
  output logic             row_tone_o,
  output logic             col_tone_o,
  output logic      [3:0]  tone_digit_o,
  output logic             hook_off_o,
  output logic             rx_mute_o,
  output logic             tx_mute_o,
  output logic             busy_o,
  output logic             pause_o,
  output logic             flash_o,
  output logic      [3:0]  port_r1_pins_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0]           mode;
    logic [3:0]           pause_t;
    logic [3:0]           flash_t;
    logic [3:0]           stat_sel;
    logic [1:0]           line_func;
    logic [3:0]           idp_t;
    logic [3:0]           tone_ctrl;
    logic [3:0]           digit;
    logic [3:0]           hook_mute;
    dcr_pkg::dcr_state_e  st;
    logic [31:0]          cnt;
    logic [3:0]           pulses;
    logic [3:0]           rdata;
    logic                 dial_pulse;
    logic                 tone_on;
    logic                 row_tone;
    logic                 col_tone;
    logic                 pause_act;
    logic                 flash_act;
    logic [3:0]           pins;
    logic                 busy;
  } dcr_state_s;

  dcr_state_s state_reg;
  dcr_state_s state_next;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] dcr_steps(input logic [3:0] code, input int unit);
    dcr_steps = 32'(int'(code) * unit);
  endfunction : dcr_steps

  function automatic logic [3:0] dcr_read(input dcr_state_s s, input logic [15:0] a);
    logic [3:0] v;
    v = 4'h0;
    case (a)
      dcr_pkg::ADDR_DIAL_MODE:  v = s.mode & 4'hB;
      dcr_pkg::ADDR_PAUSE_TIME: v = s.pause_t;
      dcr_pkg::ADDR_FLASH_TIME: v = s.flash_t;
      dcr_pkg::ADDR_STAT_SEL:   v = s.stat_sel;
      dcr_pkg::ADDR_LINE_FUNC:  v = {s.line_func, 2'b00};
      dcr_pkg::ADDR_IDP_TIME:   v = s.idp_t;
      dcr_pkg::ADDR_TONE_CTRL:  v = s.tone_ctrl & 4'hB;
      dcr_pkg::ADDR_DIAL_DIGIT: v = s.digit;
      dcr_pkg::ADDR_HOOK_MUTE:  v = s.hook_mute & 4'hB;
      default:                  v = 4'h0;
    endcase
    dcr_read = v;
  endfunction : dcr_read

  // ****************************************
  // next state
  // ****************************************
  logic        seq_busy;
  logic [31:0] period;
  logic [31:0] make_len;
  logic        pause_wr;
  logic        flash_wr;
  logic        pulse_mode;
  logic [3:0]  status_sig;

  always_comb begin
    state_next = state_reg;
    // a start edge already locks the fields it will use
    seq_busy   = (state_reg.st != dcr_pkg::ST_IDLE) || dial_start_i;
    pulse_mode = state_reg.mode[dcr_pkg::BIT_TONE_PULSE];
    period     = state_reg.mode[dcr_pkg::BIT_PULSE_RATE] ? 32'(PULSE20_CYC)
                                                         : 32'(PULSE10_CYC);
    make_len   = state_reg.mode[dcr_pkg::BIT_MAKE_BREAK] ? period / 3
                                                         : (period * 2) / 5;
    pause_wr   = 1'b0;
    flash_wr   = 1'b0;

    if (rd_i) begin
      state_next.rdata = dcr_read(state_reg, addr_i);
    end

    if (wr_i) begin
      case (addr_i)
        dcr_pkg::ADDR_DIAL_MODE: begin
          if (!seq_busy) begin
            state_next.mode = wdata_i & 4'hB;
          end
        end
        dcr_pkg::ADDR_PAUSE_TIME: begin
          if (!seq_busy) begin
            state_next.pause_t = wdata_i;
          end
        end
        dcr_pkg::ADDR_FLASH_TIME: begin
          if (!seq_busy) begin
            state_next.flash_t = wdata_i;
          end
        end
        dcr_pkg::ADDR_STAT_SEL:   state_next.stat_sel = wdata_i;
        dcr_pkg::ADDR_LINE_FUNC: begin
          state_next.line_func = wdata_i[3:2];
          pause_wr = wdata_i[dcr_pkg::BIT_PAUSE_TRIG];
          flash_wr = wdata_i[dcr_pkg::BIT_FLASH_TRIG];
        end
        dcr_pkg::ADDR_IDP_TIME: begin
          if (!seq_busy) begin
            state_next.idp_t = wdata_i;
          end
        end
        dcr_pkg::ADDR_TONE_CTRL:  state_next.tone_ctrl = wdata_i & 4'hB;
        dcr_pkg::ADDR_DIAL_DIGIT: begin
          if (!seq_busy) begin
            state_next.digit = wdata_i;
          end
        end
        dcr_pkg::ADDR_HOOK_MUTE:  state_next.hook_mute = wdata_i & 4'hB;
        default: ;
      endcase
    end

    // sequencer
    case (state_reg.st)
      dcr_pkg::ST_IDLE: begin
        state_next.dial_pulse = 1'b0;
        state_next.tone_on    = 1'b0;
        state_next.pause_act  = 1'b0;
        state_next.flash_act  = 1'b0;
        if (pause_wr && state_reg.pause_t != 4'h0) begin
          state_next.st        = dcr_pkg::ST_PAUSE;
          state_next.cnt       = dcr_steps(state_reg.pause_t, PAUSE_SEC_CYC);
          state_next.pause_act = 1'b1;
        end else if (flash_wr && state_reg.flash_t != 4'h0) begin
          state_next.st        = dcr_pkg::ST_FLASH;
          state_next.cnt       = dcr_steps(state_reg.flash_t, STEP_CYC);
          state_next.flash_act = 1'b1;
        end else if (dial_start_i && pulse_mode) begin
          if (state_reg.digit != 4'h0 && state_reg.digit < 4'h8) begin
            state_next.st         = dcr_pkg::ST_BREAK;
            state_next.pulses     = state_reg.digit;
            state_next.cnt        = period - make_len;
            state_next.dial_pulse = 1'b1;
          end
        end else if (dial_start_i && !pulse_mode) begin
          state_next.st      = dcr_pkg::ST_TONE;
          state_next.cnt     = 32'(TONE_CYC);
          state_next.tone_on = 1'b1;
        end
      end
      dcr_pkg::ST_BREAK: begin
        if (state_reg.cnt <= 32'd1) begin
          state_next.st         = dcr_pkg::ST_MAKE;
          state_next.cnt        = make_len;
          state_next.dial_pulse = 1'b0;
          state_next.pulses     = state_reg.pulses - 4'h1;
        end else begin
          state_next.cnt = state_reg.cnt - 32'd1;
        end
      end
      dcr_pkg::ST_MAKE: begin
        if (state_reg.cnt <= 32'd1) begin
          if (state_reg.pulses == 4'h0) begin
            state_next.st  = dcr_pkg::ST_IDP;
            state_next.cnt = dcr_steps(state_reg.idp_t, STEP_CYC);
          end else begin
            state_next.st         = dcr_pkg::ST_BREAK;
            state_next.cnt        = period - make_len;
            state_next.dial_pulse = 1'b1;
          end
        end else begin
          state_next.cnt = state_reg.cnt - 32'd1;
        end
      end
      dcr_pkg::ST_TONE: begin
        if (state_reg.tone_ctrl[dcr_pkg::BIT_CONT_TONE]) begin
          state_next.cnt = 32'(TONE_CYC);
        end else if (state_reg.cnt <= 32'd1) begin
          state_next.st      = dcr_pkg::ST_IDLE;
          state_next.tone_on = 1'b0;
        end else begin
          state_next.cnt = state_reg.cnt - 32'd1;
        end
      end
      dcr_pkg::ST_IDP, dcr_pkg::ST_PAUSE, dcr_pkg::ST_FLASH: begin
        if (state_reg.cnt <= 32'd1) begin
          state_next.st        = dcr_pkg::ST_IDLE;
          state_next.pause_act = 1'b0;
          state_next.flash_act = 1'b0;
        end else begin
          state_next.cnt = state_reg.cnt - 32'd1;
        end
      end
      default: state_next.st = dcr_pkg::ST_IDLE;
    endcase

    state_next.row_tone = state_next.tone_on & state_reg.tone_ctrl[dcr_pkg::BIT_ROW_EN];
    state_next.col_tone = state_next.tone_on & state_reg.tone_ctrl[dcr_pkg::BIT_COL_EN];
    state_next.busy     = (state_next.st != dcr_pkg::ST_IDLE);

    // active-low mute pins, line keep and hands-free status
    status_sig = {state_reg.line_func[1], state_reg.line_func[0],
                  ~state_next.hook_mute[dcr_pkg::BIT_RX_MUTE],
                  ~state_next.hook_mute[dcr_pkg::BIT_TX_MUTE]};
    for (int i = 0; i < 4; i++) begin
      state_next.pins[i] = state_reg.stat_sel[i] ? (status_sig[i] & port_r1_data_i[i])
                                                 : port_r1_data_i[i];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg            <= '0;
      state_reg.mode       <= dcr_pkg::RST_DIAL_MODE;
      state_reg.pause_t    <= dcr_pkg::RST_PAUSE_TIME;
      state_reg.flash_t    <= dcr_pkg::RST_FLASH_TIME;
      state_reg.stat_sel   <= dcr_pkg::RST_STAT_SEL;
      state_reg.idp_t      <= dcr_pkg::RST_IDP_TIME;
      state_reg.tone_ctrl  <= dcr_pkg::RST_TONE_CTRL;
      state_reg.digit      <= dcr_pkg::RST_DIAL_DIGIT;
      state_reg.hook_mute  <= dcr_pkg::RST_HOOK_MUTE;
      state_reg.pins       <= dcr_pkg::RST_PORT_R1;
      state_reg.st         <= dcr_pkg::ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o        = state_reg.rdata;
  assign dial_pulse_o   = state_reg.dial_pulse;
  assign tone_on_o      = state_reg.tone_on;
  assign row_tone_o     = state_reg.row_tone;
  assign col_tone_o     = state_reg.col_tone;
  assign tone_digit_o   = state_reg.digit;
  assign hook_off_o     = state_reg.hook_mute[dcr_pkg::BIT_HOOK];
  assign rx_mute_o      = state_reg.hook_mute[dcr_pkg::BIT_RX_MUTE];
  assign tx_mute_o      = state_reg.hook_mute[dcr_pkg::BIT_TX_MUTE];
  assign busy_o         = state_reg.busy;
  assign pause_o        = state_reg.pause_act;
  assign flash_o        = state_reg.flash_act;
  assign port_r1_pins_o = state_reg.pins;

  // ****************************************
  // checks
  // ****************************************
  trig_read_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == dcr_pkg::ADDR_LINE_FUNC |=> rdata_o[1:0] == 2'b00)
    else $error("trigger bits read nonzero");

  unused_read_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == dcr_pkg::ADDR_HOOK_MUTE |=> rdata_o[2] == 1'b0)
    else $error("unused bit read nonzero");

  row_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    row_tone_o |-> tone_on_o)
    else $error("row tone without tone");

  col_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    col_tone_o |-> tone_on_o)
    else $error("column tone without tone");

  pause_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !busy_o && wr_i && addr_i == dcr_pkg::ADDR_LINE_FUNC && wdata_i[1]
      && state_reg.pause_t != 4'h0 |=> pause_o && busy_o)
    else $error("pause did not start");

  digit_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_o && ce_i |=> $stable(tone_digit_o))
    else $error("digit changed while busy");

  hook_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_i && addr_i == dcr_pkg::ADDR_HOOK_MUTE |=> hook_off_o == $past(wdata_i[3]))
    else $error("hook switch not updated");

  tone_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    dial_pulse_o |-> state_reg.mode[dcr_pkg::BIT_TONE_PULSE])
    else $error("pulse output in tone mode");

  flash_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !busy_o && wr_i && addr_i == dcr_pkg::ADDR_LINE_FUNC && wdata_i[dcr_pkg::BIT_FLASH_TRIG]
      && !wdata_i[dcr_pkg::BIT_PAUSE_TRIG] && state_reg.flash_t != 4'h0 |=> flash_o && busy_o)
    else $error("flash did not start");

  mute_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_i && addr_i == dcr_pkg::ADDR_HOOK_MUTE |=> rx_mute_o == $past(wdata_i[1])
      && tx_mute_o == $past(wdata_i[0]))
    else $error("mute outputs not updated");

  mode_read_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == dcr_pkg::ADDR_DIAL_MODE |=> rdata_o[2] == 1'b0)
    else $error("unused mode bit read nonzero");

endmodule : dcr_top

// ===== tb/dcr_line_model.sv
// Purpose: line and handset side seen by the dialer outputs
// Assumes: dialer outputs are registered on mclk_i
// Notes:   counts break pulses and times the last timed burst
`timescale 1ns/1ns
module dcr_line_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        dial_pulse_i,
  input  wire logic        timed_i,
  output logic      [15:0] pulses_o,
  output logic      [15:0] brk_len_o,
  output logic      [15:0] run_len_o
);
  logic [15:0] brk_cnt;
  logic [15:0] run_cnt;
  logic        brk_q;
  logic        run_q;

  // ****************************************
  // break and burst timing
  // ****************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_cnt   <= 16'h0000;
      run_cnt   <= 16'h0000;
      brk_q     <= 1'b0;
      run_q     <= 1'b0;
      pulses_o  <= 16'h0000;
      brk_len_o <= 16'h0000;
      run_len_o <= 16'h0000;
    end else begin
      brk_q <= dial_pulse_i;
      run_q <= timed_i;
      brk_cnt <= dial_pulse_i ? brk_cnt + 16'h0001 : 16'h0000;
      run_cnt <= timed_i ? run_cnt + 16'h0001 : 16'h0000;
      if (brk_q && !dial_pulse_i) begin
        brk_len_o <= brk_cnt;
        pulses_o  <= pulses_o + 16'h0001;
      end
      if (run_q && !timed_i) begin
        run_len_o <= run_cnt;
      end
    end
  end
endmodule : dcr_line_model

// ===== tb/tb.sv
// Purpose: register and sequence tests for the dialer control bank
// Assumes: shortened timing parameters, strobes driven at falling edge
// Notes:   expectations follow the register table and chosen counts
`timescale 1ns/1ns
module tb;
  localparam int PS = 20;
  localparam int ST = 10;
  localparam int P10 = 50;
  localparam int P20 = 25;
  localparam int TC = 20;
  localparam logic [3:0] RV [9] = '{4'h0, 4'h4, 4'h6, 4'h0, 4'h0, 4'h8, 4'h3, 4'h0, 4'h3};
  localparam logic [3:0] WD [9] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hC, 4'hF, 4'hF, 4'hF, 4'hF};
  localparam logic [3:0] MK [9] = '{4'hB, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hB, 4'hF, 4'hB};

  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        dial_start_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [3:0]  wdata_i = 4'h0;
  logic [3:0]  port_r1_data_i = 4'hF;
  logic [3:0]  rdata_o, tone_digit_o, port_r1_pins_o;
  logic        dial_pulse_o, tone_on_o, row_tone_o, col_tone_o, hook_off_o;
  logic        rx_mute_o, tx_mute_o, busy_o, pause_o, flash_o;
  logic [15:0] pulses, brk_len, run_len, p0;
  int          mismatches = 0;
  int          checked = 0;

  always #20 mclk_i = ~mclk_i;

  dcr_top #(.PAUSE_SEC_CYC(PS), .STEP_CYC(ST), .PULSE10_CYC(P10), .PULSE20_CYC(P20), .TONE_CYC(TC)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .dial_start_i(dial_start_i), .port_r1_data_i(port_r1_data_i),
    .rdata_o(rdata_o), .dial_pulse_o(dial_pulse_o), .tone_on_o(tone_on_o), .row_tone_o(row_tone_o),
    .col_tone_o(col_tone_o), .tone_digit_o(tone_digit_o), .hook_off_o(hook_off_o),
    .rx_mute_o(rx_mute_o), .tx_mute_o(tx_mute_o), .busy_o(busy_o), .pause_o(pause_o),
    .flash_o(flash_o), .port_r1_pins_o(port_r1_pins_o));

  dcr_line_model line (
    .mclk_i(mclk_i), .rst_i(rst_i), .dial_pulse_i(dial_pulse_o),
    .timed_i(pause_o | flash_o | tone_on_o), .pulses_o(pulses), .brk_len_o(brk_len),
    .run_len_o(run_len));

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : cmp4

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : cmp16

  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : idle

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(negedge mclk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge mclk_i);
    wr_i = 1'b0;
  endtask : wr

  task automatic chk_rd(input logic [15:0] a, input logic [3:0] exp);
    @(negedge mclk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge mclk_i);
    rd_i = 1'b0;
    @(negedge mclk_i);
    cmp4(rdata_o, exp);
  endtask : chk_rd

  task automatic start();
    p0 = pulses;
    @(negedge mclk_i);
    dial_start_i = 1'b1;
    @(negedge mclk_i);
    dial_start_i = 1'b0;
  endtask : start

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge mclk_i);
    while ((busy_o | tone_on_o) !== 1'b0 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
      $display("Error at %0t: sequence never ended", $time);
    end
    idle(2);
  endtask : wait_idle

  // ****************************************
  // tests
  // ****************************************
  initial begin
    idle(2);
    rst_i = 1'b0;
    cmp4(port_r1_pins_o, 4'hF);
    cmp4({hook_off_o, 1'b0, rx_mute_o, tx_mute_o}, 4'h3);
    for (int i = 0; i < 9; i++) chk_rd(16'hFF10 + 16'(i), RV[i]);
    chk_rd(16'hFF19, 4'h0);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) wr(16'hFF10 + 16'(i), WD[i]);
    for (int i = 0; i < 9; i++) chk_rd(16'hFF10 + 16'(i), WD[i] & MK[i]);
    for (int i = 0; i < 9; i++) wr(16'hFF10 + 16'(i), RV[i]);
    $display("test read masks done");
    wr(16'hFF14, 4'h8);
    wr(16'hFF18, 4'h1);
    wr(16'hFF13, 4'hF);
    idle(2);
    cmp4({2'b00, rx_mute_o, tx_mute_o}, 4'h1);
    cmp4(port_r1_pins_o, 4'hA);
    wr(16'hFF13, 4'h5);
    port_r1_data_i = 4'h5;
    idle(2);
    cmp4(port_r1_pins_o, 4'h0);
    wr(16'hFF13, 4'h0);
    wr(16'hFF18, 4'h8);
    idle(2);
    cmp4(port_r1_pins_o, 4'h5);
    cmp4({hook_off_o, 1'b0, rx_mute_o, tx_mute_o}, 4'h8);
    wr(16'hFF14, 4'h0);
    $display("test pins and mutes done");
    wr(16'hFF11, 4'h2);
    wr(16'hFF14, 4'h2);
    wr(16'hFF11, 4'h7);
    chk_rd(16'hFF11, 4'h2);
    chk_rd(16'hFF14, 4'h0);
    cmp4({3'b000, pause_o}, 4'h1);
    wait_idle();
    cmp16(run_len, 16'(2 * PS));
    wr(16'hFF12, 4'h3);
    wr(16'hFF14, 4'h1);
    wait_idle();
    cmp16(run_len, 16'(3 * ST));
    wr(16'hFF11, 4'h0);
    wr(16'hFF12, 4'h0);
    wr(16'hFF14, 4'h3);
    idle(2);
    cmp4({3'b000, busy_o}, 4'h0);
    $display("test pause and flash done");
    wr(16'hFF10, 4'h8);
    wr(16'hFF17, 4'h3);
    start();
    wr(16'hFF17, 4'h9);
    wait_idle();
    chk_rd(16'hFF17, 4'h3);
    cmp16(pulses - p0, 16'h0003);
    cmp16(brk_len, 16'(P10 - 2 * P10 / 5));
    wr(16'hFF10, 4'hB);
    wr(16'hFF17, 4'h2);
    start();
    wait_idle();
    cmp16(pulses - p0, 16'h0002);
    cmp16(brk_len, 16'(P20 - P20 / 3));
    wr(16'hFF17, 4'h8);
    start();
    wait_idle();
    cmp16(pulses - p0, 16'h0000);
    $display("test pulse dialing done");
    wr(16'hFF10, 4'h0);
    wr(16'hFF16, 4'h1);
    wr(16'hFF17, 4'h5);
    start();
    idle(3);
    cmp4({3'b000, tone_on_o}, 4'h1);
    cmp4({2'b00, row_tone_o, col_tone_o}, 4'h1);
    cmp4(tone_digit_o, 4'h5);
    wait_idle();
    cmp16(run_len, 16'(TC));
    cmp16(pulses - p0, 16'h0000);
    wr(16'hFF16, 4'hB);
    start();
    idle(3 * TC);
    cmp4({3'b000, tone_on_o}, 4'h1);
    cmp4({2'b00, row_tone_o, col_tone_o}, 4'h3);
    wr(16'hFF16, 4'h3);
    wait_idle();
    cmp4({3'b000, tone_on_o}, 4'h0);
    $display("test tone dialing done");
    ce_i = 1'b0;
    wr(16'hFF17, 4'h6);
    ce_i = 1'b1;
    chk_rd(16'hFF17, 4'h5);
    $display("test clock enable done");
    summarize();
  end

  initial begin
    #(40 * 20000);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : tb
